// ===== rtl/scr_pkg.sv
// Shared constants and types for the serial configuration register port.
package scr_pkg;
  // Configuration word layout and defaults.
  localparam int          CFG_W       = 12;
  localparam int          REV_W       = 4;
  localparam int          RANGE_MSB   = 11;
  localparam int          RANGE_LSB   = 9;
  localparam int          FORMAT_BIT  = 8;
  localparam int          VARIANT_BIT = 7;
  localparam int          QDIV_BIT    = 6;
  localparam int          TEST_BIT    = 0;
  localparam logic [11:0] ZERO_MASK   = 12'h03e;
  localparam logic [11:0] CFG_RESET   = 12'hf00;
  localparam logic [1:0]  QDIV_LAST   = 2'h3;

  // Readback stream: each half is word, revision, zeros, then the pattern.
  localparam logic [71:0] PAT_LONG    = 72'h30_f066_0124_80f6_9055;
  localparam logic [55:0] PAT_SHORT   = 56'h30_f066_0124_80f6;
  localparam logic [9:0]  PAT_LONG_N  = 10'h048;
  localparam logic [9:0]  PAT_SHORT_N = 10'h038;
  localparam logic [9:0]  HALF_LONG   = 10'h140;
  localparam logic [9:0]  HALF_SHORT  = 10'h100;

  // Timing, in ns, and the derived counts of aclk cycles (least times round up).
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          T_RST_NS      = 1000;
  localparam int          RST_WAIT_NS   = 2000;
  localparam int          RD_GAP_NS     = 2000;
  localparam logic [7:0]  RST_CYC      = 8'((T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  RST_WAIT_CYC = 8'((RST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0]  RD_GAP_CYC   = 8'((RD_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Controller registers on AXI4-Lite.
  localparam logic [3:0]  ADDR_CFG    = 4'h0;
  localparam logic [3:0]  ADDR_CMD    = 4'h4;
  localparam logic [3:0]  ADDR_STAT   = 4'h8;
  localparam logic [3:0]  ADDR_RDATA  = 4'hc;
  localparam int          CMD_WRITE   = 0;
  localparam int          CMD_READ    = 1;
  localparam int          CMD_TOGGLE  = 2;
  localparam int          RB_BITS     = 16;
  localparam logic [3:0]  RB_LAST     = 4'hf;
  localparam logic [3:0]  BIT_TOP     = 4'hb;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_RST   = 3'h1,
    ST_WAIT  = 3'h2,
    ST_SHIFT = 3'h3,
    ST_GAP   = 3'h4,
    ST_READ  = 3'h5
  } scr_hstate_t;
endpackage

// ===== rtl/scr_link_if.sv
// Pin-level link between the configuration host and the converter's port.
`timescale 1ns/1ns
interface scr_link_if;
  logic sys_clk;
  logic cfg_shift_clk;
  logic cfg_din;
  logic cfg_strobe_n;
  logic integrate_toggle;
  logic readout_shift_clock;
  logic dout;

  modport host (
    output sys_clk, cfg_shift_clk, cfg_din, cfg_strobe_n,
    output integrate_toggle, readout_shift_clock,
    input  dout
  );
  modport dev (
    input  sys_clk, cfg_shift_clk, cfg_din, cfg_strobe_n,
    input  integrate_toggle, readout_shift_clock,
    output dout
  );
endinterface

// ===== rtl/scr_dev.sv
// Converter end: twelve-bit configuration register, readback and clock divider.
`timescale 1ns/1ns
module scr_dev
  import scr_pkg::*;
#(
  parameter logic [3:0] REV_ID = 4'h5  // Arbitrary revision code.
) (
  // Clock and reset.
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Link.
  scr_link_if.dev         link,
  // Configuration seen by the converter core.
  output logic [2:0]      range_sel,
  output logic            wide_format,
  output logic            variant_sel,
  output logic            sysclk_quarter_divide,
  output logic            inputs_disconnect,
  output logic            internal_clk_tick,
  output logic            readback_active
);
  logic [11:0] cfg_ff;
  logic [10:0] shift_ff;
  logic [3:0]  bitcnt_ff;
  logic        cfg_prev_ff;
  logic        rd_prev_ff;
  logic        sys_prev_ff;
  logic [1:0]  qdiv_ff;
  logic        tick_ff;
  logic        rb_en_ff;
  logic [9:0]  rb_cnt_ff;
  logic        dout_ff;
  logic        cfg_fall;
  logic        rd_rise;
  logic        sys_rise;
  logic [9:0]  half;

  // Picks stream bit n: word MSB first, revision, zero fill, pattern at the tail.
  function automatic logic rb_bit(input logic [11:0] c, input logic [9:0] n,
                                  input logic [9:0] h);
    logic [9:0] p;
    logic [9:0] k;
    p = (n < h) ? n : 10'(n - h);
    k = 10'(h - 10'h001 - p);
    if (p < 10'(CFG_W))
      rb_bit = c[4'(CFG_W - 1) - 4'(p)];
    else if (p < 10'(CFG_W + REV_W))
      rb_bit = REV_ID[2'(CFG_W + REV_W - 1) - 2'(p)];
    else if (c[FORMAT_BIT])
      rb_bit = (k < PAT_LONG_N) ? PAT_LONG[7'(k)] : 1'b0;
    else
      rb_bit = (k < PAT_SHORT_N) ? PAT_SHORT[6'(k)] : 1'b0;
  endfunction

  assign cfg_fall = cfg_prev_ff & ~link.cfg_shift_clk;
  assign rd_rise  = ~rd_prev_ff & link.readout_shift_clock;
  assign sys_rise = ~sys_prev_ff & link.sys_clk;
  assign half     = cfg_ff[FORMAT_BIT] ? HALF_LONG : HALF_SHORT;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_prev_ff <= 1'b0;
      rd_prev_ff  <= 1'b0;
      sys_prev_ff <= 1'b0;
    end else begin
      cfg_prev_ff <= link.cfg_shift_clk;
      rd_prev_ff  <= link.readout_shift_clock;
      sys_prev_ff <= link.sys_clk;
    end
  end

  // A strobe restarts the bit count; the word changes only after all twelve bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff    <= CFG_RESET;  // R9
      shift_ff  <= '0;
      bitcnt_ff <= '0;
    end else if (!link.cfg_strobe_n) begin
      bitcnt_ff <= '0;
    end else if (cfg_fall && !link.integrate_toggle) begin  // R10
      shift_ff <= {shift_ff[9:0], link.cfg_din};
      if (bitcnt_ff == BIT_TOP) begin
        cfg_ff    <= {shift_ff, link.cfg_din};  // R10
        bitcnt_ff <= '0;
      end else begin
        bitcnt_ff <= bitcnt_ff + 4'h1;
      end
    end
  end

  // Readback is armed by a completed write and disarmed by the next strobe.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rb_en_ff  <= 1'b0;
      rb_cnt_ff <= '0;
      dout_ff   <= 1'b0;
    end else if (!link.cfg_strobe_n) begin
      rb_en_ff  <= 1'b0;
      rb_cnt_ff <= '0;
      dout_ff   <= 1'b0;
    end else if (cfg_fall && !link.integrate_toggle && bitcnt_ff == BIT_TOP) begin
      rb_en_ff  <= 1'b1;
      rb_cnt_ff <= '0;
    end else if (rb_en_ff && rd_rise) begin
      dout_ff <= rb_bit(cfg_ff, rb_cnt_ff, half);  // R11
      if (rb_cnt_ff == 10'(half + half - 10'h001))
        rb_en_ff <= 1'b0;
      rb_cnt_ff <= rb_cnt_ff + 10'h001;
    end
  end

  // Internal clock tick: every system clock rise, or every fourth one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qdiv_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      if (sys_rise)
        qdiv_ff <= qdiv_ff + 2'h1;
      tick_ff <= sys_rise && (!cfg_ff[QDIV_BIT] || qdiv_ff == QDIV_LAST);  // R4
    end
  end

  assign link.dout             = dout_ff;
  assign range_sel             = cfg_ff[RANGE_MSB:RANGE_LSB];  // R12
  assign wide_format           = cfg_ff[FORMAT_BIT];  // R14
  assign variant_sel           = cfg_ff[VARIANT_BIT];
  assign sysclk_quarter_divide = cfg_ff[QDIV_BIT];
  // Only the input switches follow the test bit; integration sequencing does not.
  assign inputs_disconnect     = cfg_ff[TEST_BIT];  // R7 R8
  assign internal_clk_tick     = tick_ff;
  assign readback_active       = rb_en_ff;
endmodule

// ===== rtl/scr_host.sv
// Host end: AXI4-Lite controller that writes and reads back the configuration word.
// How it works
// R1: Wait 2 us after strobe release.
// R2: Leave 2 us between write and readback.
// R3: Hold reset strobe low at least 1 us.
// R4: Divider bit divides system clock by four.
// R5: Change integrate toggle aligned to system clock; a write command clears it on any phase.
// R6: Always write zeros to bits five..one.
// R7: Test bit disconnects all analog inputs.
// R8: Test mode leaves integration sequencing unchanged.
// R9: Test bit defaults to zero.
// R10: Toggle low, strobe, twelve bits MSB-first, falling-edge latch.
// R11: Readback: word, revision, then test pattern.
// R12: Bits 11..9 pick range; 7 largest.
// R13: Keep system clock running; toggle afterwards.
// R14: Bit eight: 16-bit clear, 20-bit set.
// R15: Software sets variant bit to match grade.
//
// The address map and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ns
module scr_host
  import scr_pkg::*;
#(
  parameter int SHIFT_HALF = 2
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels.
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Link.
  scr_link_if.host         link
);
  if (SHIFT_HALF < 1 || SHIFT_HALF > 255) begin : g_chk
    $error("SHIFT_HALF must be 1 to 255");
  end
  localparam logic [7:0] HALF_LAST = 8'(SHIFT_HALF - 1);

  scr_hstate_t state_ff;
  logic [7:0]  cnt_ff;
  logic [3:0]  bit_ff;
  logic        phase_ff;
  logic [11:0] cfg_ff;
  logic [15:0] rdata_ff;
  logic        written_ff;
  logic        rb_valid_ff;
  logic        tog_pend_ff;
  logic        sys_clk_ff;
  logic        tog_ff;
  logic        sclk_ff;
  logic        din_ff;
  logic        strobe_n_ff;
  logic        rclk_ff;
  logic [3:0]  awaddr_ff;
  logic        aw_got_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        w_got_ff;
  logic        awready_ff;
  logic        wready_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        arready_ff;
  logic        rvalid_ff;
  logic [31:0] rdat_ff;
  logic [1:0]  rresp_ff;
  logic        do_wr;
  logic        idle;
  logic        cmd_wr;
  logic        cmd_rd;
  logic        half_end;

  assign do_wr    = aw_got_ff && w_got_ff && !bvalid_ff;
  assign idle     = state_ff == ST_IDLE;
  assign cmd_wr   = do_wr && awaddr_ff == ADDR_CMD && wstrb_ff[0];
  assign cmd_rd   = cmd_wr && wdata_ff[CMD_READ] && written_ff;
  assign half_end = cnt_ff == HALF_LAST;

  // Write address and data are taken independently; the response follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      aw_got_ff  <= 1'b0;
      awaddr_ff  <= '0;
    end else if (s_axi_awvalid && awready_ff) begin
      awready_ff <= 1'b0;
      aw_got_ff  <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end else if (bvalid_ff && s_axi_bready) begin
      aw_got_ff <= 1'b0;
    end else if (!aw_got_ff && !bvalid_ff) begin
      awready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      wdata_ff  <= '0;
      wstrb_ff  <= '0;
    end else if (s_axi_wvalid && wready_ff) begin
      wready_ff <= 1'b0;
      w_got_ff  <= 1'b1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end else if (bvalid_ff && s_axi_bready) begin
      w_got_ff <= 1'b0;
    end else if (!w_got_ff && !bvalid_ff) begin
      wready_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (awaddr_ff == ADDR_CFG || awaddr_ff == ADDR_CMD) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // The word is stored with bits five..one forced to zero; variant passes as written.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_ff <= CFG_RESET & ~ZERO_MASK;
    end else if (do_wr && awaddr_ff == ADDR_CFG) begin
      if (wstrb_ff[0])
        cfg_ff[7:0] <= wdata_ff[7:0] & ~ZERO_MASK[7:0];  // R6 R15
      if (wstrb_ff[1])
        cfg_ff[11:8] <= wdata_ff[11:8];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdat_ff    <= '0;
      rresp_ff   <= RESP_OKAY;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_CFG:   rdat_ff <= {20'h0_0000, cfg_ff};
        ADDR_STAT:  rdat_ff <= {28'h000_0000, written_ff, tog_ff, rb_valid_ff, !idle};
        ADDR_RDATA: rdat_ff <= {16'h0000, rdata_ff};
        ADDR_CMD:   rdat_ff <= '0;
        default: begin
          rdat_ff  <= '0;
          rresp_ff <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end else if (!rvalid_ff) begin
      arready_ff <= 1'b1;
    end
  end

  // Free-running system clock at half the bus clock, never stopped.
  always_ff @(posedge aclk) begin
    if (!aresetn)
      sys_clk_ff <= 1'b0;
    else
      sys_clk_ff <= ~sys_clk_ff;  // R13
  end

  // Toggle requests wait for the next system clock rise so integration timing stays aligned.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tog_pend_ff <= 1'b0;
      tog_ff      <= 1'b0;
    end else if (cmd_wr && wdata_ff[CMD_WRITE] && idle) begin
      tog_pend_ff <= 1'b0;
      tog_ff      <= 1'b0;  // R10
    end else if (tog_pend_ff && !sys_clk_ff) begin
      tog_pend_ff <= 1'b0;
      tog_ff      <= ~tog_ff;  // R5 R13
    end else if (cmd_wr && wdata_ff[CMD_TOGGLE] && idle) begin
      tog_pend_ff <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= '0;
      bit_ff      <= '0;
      phase_ff    <= 1'b0;
      sclk_ff     <= 1'b0;
      din_ff      <= 1'b0;
      strobe_n_ff <= 1'b1;
      rclk_ff     <= 1'b0;
      written_ff  <= 1'b0;
      rb_valid_ff <= 1'b0;
      rdata_ff    <= '0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          cnt_ff <= '0;
          if (cmd_wr && wdata_ff[CMD_WRITE]) begin
            state_ff    <= ST_RST;
            strobe_n_ff <= 1'b0;
            written_ff  <= 1'b0;
            rb_valid_ff <= 1'b0;
          end else if (cmd_rd) begin
            state_ff    <= ST_READ;
            bit_ff      <= '0;
            phase_ff    <= 1'b0;
            rclk_ff     <= 1'b1;
            rb_valid_ff <= 1'b0;
          end
        end
        ST_RST: begin
          cnt_ff <= cnt_ff + 8'h01;
          if (cnt_ff == 8'(RST_CYC - 8'h01)) begin  // R3
            strobe_n_ff <= 1'b1;
            cnt_ff      <= '0;
            state_ff    <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          cnt_ff <= cnt_ff + 8'h01;
          if (cnt_ff == 8'(RST_WAIT_CYC - 8'h01)) begin  // R1
            cnt_ff   <= '0;
            bit_ff   <= BIT_TOP;
            phase_ff <= 1'b0;
            sclk_ff  <= 1'b1;
            din_ff   <= cfg_ff[BIT_TOP];  // R10
            state_ff <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          cnt_ff <= cnt_ff + 8'h01;
          if (half_end) begin
            cnt_ff <= '0;
            if (!phase_ff) begin
              sclk_ff  <= 1'b0;
              phase_ff <= 1'b1;
            end else if (bit_ff == '0) begin
              state_ff <= ST_GAP;
            end else begin
              bit_ff   <= bit_ff - 4'h1;
              din_ff   <= cfg_ff[bit_ff - 4'h1];  // R10
              sclk_ff  <= 1'b1;
              phase_ff <= 1'b0;
            end
          end
        end
        ST_GAP: begin
          cnt_ff <= cnt_ff + 8'h01;
          if (cnt_ff == 8'(RD_GAP_CYC - 8'h01)) begin  // R2
            written_ff <= 1'b1;
            state_ff   <= ST_IDLE;
          end
        end
        ST_READ: begin
          cnt_ff <= cnt_ff + 8'h01;
          if (half_end) begin
            cnt_ff <= '0;
            if (!phase_ff) begin
              rclk_ff  <= 1'b0;
              phase_ff <= 1'b1;
            end else begin
              rdata_ff <= {rdata_ff[14:0], link.dout};
              if (bit_ff == RB_LAST) begin
                rb_valid_ff <= 1'b1;
                state_ff    <= ST_IDLE;
              end else begin
                bit_ff   <= bit_ff + 4'h1;
                rclk_ff  <= 1'b1;
                phase_ff <= 1'b0;
              end
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign s_axi_awready            = awready_ff;
  assign s_axi_wready             = wready_ff;
  assign s_axi_bvalid             = bvalid_ff;
  assign s_axi_bresp              = bresp_ff;
  assign s_axi_arready            = arready_ff;
  assign s_axi_rvalid             = rvalid_ff;
  assign s_axi_rdata              = rdat_ff;
  assign s_axi_rresp              = rresp_ff;
  assign link.sys_clk             = sys_clk_ff;
  assign link.cfg_shift_clk       = sclk_ff;
  assign link.cfg_din             = din_ff;
  assign link.cfg_strobe_n        = strobe_n_ff;
  assign link.integrate_toggle    = tog_ff;
  assign link.readout_shift_clock = rclk_ff;
endmodule

// ===== verification/scr_link_checker.sv
// Timing checker watching the configuration link between host and converter.
`timescale 1ns/1ns
module scr_link_checker (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Link signals.
  input wire logic sys_clk,
  input wire logic cfg_shift_clk,
  input wire logic cfg_din,
  input wire logic cfg_strobe_n,
  input wire logic integrate_toggle,
  input wire logic readout_shift_clock,
  input wire logic dout
);
  logic [7:0] low_cnt_ff;
  logic [7:0] rel_cnt_ff;
  logic [7:0] fall_cnt_ff;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Counters saturate so that long idle stretches never wrap into a false short gap.
  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_strobe_n) begin
      low_cnt_ff <= 8'h00;
    end else if (low_cnt_ff != 8'hff) begin
      low_cnt_ff <= low_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !cfg_strobe_n) begin
      rel_cnt_ff <= 8'h00;
    end else if (rel_cnt_ff != 8'hff) begin
      rel_cnt_ff <= rel_cnt_ff + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_shift_clk) begin
      fall_cnt_ff <= 8'h00;
    end else if (fall_cnt_ff != 8'hff) begin
      fall_cnt_ff <= fall_cnt_ff + 8'h01;
    end
  end

  // Phase lengths match the half period of two cycles that the bench sets on the host.
  sequence s_cfg_high;
    cfg_shift_clk [*2];
  endsequence
  sequence s_cfg_low;
    !cfg_shift_clk [*2];
  endsequence
  sequence s_rd_high;
    readout_shift_clock [*2];
  endsequence
  sequence s_rd_low;
    !readout_shift_clock [*2];
  endsequence

  a_strobe_width: assert property ($rose(cfg_strobe_n) |-> low_cnt_ff == 8'h0a)
    else $error("Strobe low time is not ten cycles.");
  a_reset_wait: assert property ($rose(cfg_shift_clk) |-> rel_cnt_ff >= 8'h14)
    else $error("Shift clock rose too soon after strobe release.");
  a_write_gap: assert property ($rose(readout_shift_clock) |-> fall_cnt_ff >= 8'h14)
    else $error("Readback clock started too soon after the write.");
  a_din_steady: assert property ($changed(cfg_din) |-> !$past(cfg_shift_clk))
    else $error("Serial data moved while the shift clock was high.");
  a_toggle_low: assert property (!cfg_strobe_n || $rose(cfg_shift_clk) |-> !integrate_toggle)
    else $error("Integrate toggle high during a configuration write.");
  a_shift_phase: assert property ($rose(cfg_shift_clk) |-> s_cfg_high ##1 s_cfg_low)
    else $error("Shift clock phase length wrong.");
  a_sysclk_runs: assert property ($past(aresetn) |-> $changed(sys_clk))
    else $error("System clock stopped.");
  a_toggle_sync: assert property ($changed(integrate_toggle) |-> $rose(sys_clk) || $fell(cfg_strobe_n))
    else $error("Integrate toggle moved off a system clock rise.");
  a_read_phase: assert property ($rose(readout_shift_clock) |-> s_rd_high ##1 s_rd_low)
    else $error("Readback clock phase length wrong.");
  // A strobe clears the output bit, so a change after a low strobe is legal too.
  a_dout_launch: assert property ($past(aresetn) && $changed(dout) |->
    $past(readout_shift_clock) || !$past(cfg_strobe_n))
    else $error("Readback data moved without a readback clock rise or strobe.");
endmodule

// ===== verification/tb.sv
// Self-checking bench: AXI4-Lite host end driving the converter end over the link.
`timescale 1ns/1ns
module tb
  import scr_pkg::*;
;
  localparam logic [3:0] REV = 4'h9;  // Arbitrary revision code.
  logic        aclk;
  logic        aresetn;
  logic [3:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [3:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [2:0]  range_sel;
  logic        wide_format;
  logic        variant_sel;
  logic        qdiv;
  logic        disc;
  logic        tick;
  logic        rb_act;
  int          n_mismatch;
  int          total_checks;
  logic [31:0] seed;

  scr_link_if link_if ();

  scr_host #(.SHIFT_HALF(2)) scr_host_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link_if));

  scr_dev #(.REV_ID(REV)) scr_dev_inst (
    .aclk(aclk), .aresetn(aresetn), .link(link_if), .range_sel(range_sel),
    .wide_format(wide_format), .variant_sel(variant_sel), .sysclk_quarter_divide(qdiv),
    .inputs_disconnect(disc), .internal_clk_tick(tick), .readback_active(rb_act));

  scr_link_checker scr_link_checker_inst (
    .aclk(aclk), .aresetn(aresetn), .sys_clk(link_if.sys_clk),
    .cfg_shift_clk(link_if.cfg_shift_clk), .cfg_din(link_if.cfg_din),
    .cfg_strobe_n(link_if.cfg_strobe_n), .integrate_toggle(link_if.integrate_toggle),
    .readout_shift_clock(link_if.readout_shift_clock), .dout(link_if.dout));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [11:0] stored(input logic [11:0] c);
    return c & ~ZERO_MASK;
  endfunction

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_write(input logic [3:0] a, input logic [31:0] v, output logic [1:0] r);
    int n;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    if (n == 100) begin
      n_mismatch++;
      final_report();
    end
    @(posedge aclk);
  endtask

  task automatic axi_read(input logic [3:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    v = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n == 100) begin
      n_mismatch++;
      final_report();
    end
    @(posedge aclk);
  endtask

  // Polls the status word until the masked bits reach the wanted value.
  task automatic poll(input logic [3:0] mask, input logic [3:0] want);
    logic [31:0] v;
    logic [1:0]  r;
    int          n;
    for (n = 0; n < 300; n++) begin
      axi_read(ADDR_STAT, v, r);
      if ((v[3:0] & mask) == want) break;
    end
    if (n == 300) begin
      n_mismatch++;
      final_report();
    end
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [11:0] c;
    logic [11:0] e;
    int          n;
    n_mismatch = 0;
    total_checks = 0;
    seed = 32'hbeab_55c4;
    aresetn <= 1'b0;
    {awaddr, araddr, wdata} <= '0;
    {awvalid, wvalid, bready, arvalid, rready} <= '0;
    wstrb <= 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read(ADDR_CFG, d, r);
    chk(d, {20'h0_0000, CFG_RESET});
    chk({25'h0, range_sel, wide_format, variant_sel, qdiv, disc}, 32'h0000_0078);
    chk({31'h0, rb_act}, 32'h0);
    axi_write(4'h6, 32'h0000_0fff, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_read(4'h6, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    axi_read(ADDR_CMD, d, r);
    chk(d, 32'h0);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      c = (i == 0) ? 12'hfff : (i == 1) ? 12'h041 : (i == 2) ? 12'h000 : seed[11:0];
      e = stored(c);
      if (i == 1) begin
        axi_write(ADDR_CMD, 32'h0000_0004, r);
        poll(4'h4, 4'h4);
        chk({31'h0, link_if.integrate_toggle}, 32'h1);
      end
      axi_write(ADDR_CFG, {20'h0_0000, c}, r);
      axi_read(ADDR_CFG, d, r);
      chk(d, {20'h0_0000, e});
      axi_write(ADDR_CMD, 32'h0000_0001, r);
      poll(4'h1, 4'h0);
      chk({31'h0, link_if.integrate_toggle}, 32'h0);
      chk({25'h0, range_sel, wide_format, variant_sel, qdiv, disc}, {25'h0, e[11:6], e[0]});
      n = 0;
      repeat (80) begin
        @(posedge aclk);
        n += int'(tick === 1'b1);
      end
      // Window edges may clip one pulse either way.
      chk({31'h0, (n >= (e[6] ? 9 : 39) && n <= (e[6] ? 11 : 41))}, 32'h1);
      axi_write(ADDR_CMD, 32'h0000_0002, r);
      poll(4'h3, 4'h2);
      chk({31'h0, rb_act}, 32'h1);
      axi_read(ADDR_RDATA, d, r);
      chk(d, {16'h0000, e, REV});
    end
    final_report();
  end
endmodule
